// [hdl/pfe_pkg.sv]
/*
  Package for the event and fault flag bank of a four-channel power-sourcing group.
  Holds command codes, field layouts and reset values.
  Assumes one 50 MHz clock and a command-code register port driven by a serial front end.
*/
package pfe_pkg;
  localparam logic [7:0] CMD_DETCLS_RO  = 8'h04;
  localparam logic [7:0] CMD_DETCLS_CR  = 8'h05;
  localparam logic [7:0] CMD_FAULT_RO   = 8'h06;
  localparam logic [7:0] CMD_FAULT_CR   = 8'h07;
  localparam logic [7:0] CMD_STLIM_RO   = 8'h08;
  localparam logic [7:0] CMD_STLIM_CR   = 8'h09;
  localparam logic [7:0] CMD_SUPPLY_RO  = 8'h0a;
  localparam logic [7:0] CMD_SUPPLY_CR  = 8'h0b;
  localparam logic [7:0] CMD_FWREV      = 8'h41;
  localparam logic [7:0] FWREV_SAFE     = 8'hff;
  localparam logic [7:0] UNMAPPED_DATA  = 8'h00;
  // supply register bit positions
  localparam int SUP_THERMAL  = 7;
  localparam int SUP_VDD_UV   = 6;
  localparam int SUP_VDD_WARN = 5;
  localparam int SUP_VPWR_UV  = 4;
  localparam int SUP_FASTSD   = 1;
  localparam int SUP_MEMFLT   = 0;
  localparam logic [7:0] SUP_POR_VALUE  = 8'h70;
  localparam logic [7:0] SUP_KEEP_MASK  = 8'hf0;
  localparam logic [7:0] SUP_LIVE_MASK  = 8'hf3;
  localparam logic [3:0] NIBBLE_ZERO    = 4'h0;
  localparam logic [3:0] NIBBLE_ONES    = 4'hf;

  // per-channel event inputs from the port state machines
  typedef struct packed {
    logic [3:0] class_done;
    logic [3:0] detect_done;
    logic [3:0] class_changed;
    logic [3:0] detect_changed;
    logic [3:0] disconnect;
    logic [3:0] overload;
    logic [3:0] current_limit;
    logic [3:0] start_timeout;
    logic [3:0] start_discovery_err;
    logic [3:0] channel_off;
    logic [3:0] auto_mode;
  } pfe_chan_ev_t;

  // device-wide supply and safety inputs
  typedef struct packed {
    logic       thermal;
    logic       vdd_uv;
    logic       vdd_warn;
    logic       vpwr_uv;
    logic       vpwr_above_30v;
    logic       vpwr_below_uvlo;
    logic       mem_error;
  } pfe_supply_t;
endpackage : pfe_pkg

// [hdl/pfe_flags.sv]
/*
  Event and fault flag bank for one group of four channels.
  Read by command code; odd codes of each pair clear on read.
  Assumes the command port gives a one-cycle read strobe with a stable code,
  and that event inputs are one-cycle pulses synchronous to sys_clk_i.
*/
`timescale 1ns/1ns
`default_nettype none

module pfe_flags (
  input  wire logic                  sys_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  por_i,
  input  wire logic                  rd_i,
  input  wire logic [7:0]            cmd_i,
  output logic      [7:0]            rd_data_o,
  input  wire pfe_pkg::pfe_chan_ev_t chan_ev_i,
  input  wire pfe_pkg::pfe_supply_t  supply_i,
  input  wire logic                  class_change_select_i,
  input  wire logic                  detect_change_select_i,
  input  wire logic [3:0]            power_enable_change_flag_i,
  input  wire logic [3:0]            channel_power_on_command_i,
  input  wire logic [3:0]            channel_powered_i,
  input  wire logic                  multibit_priority_select_i,
  input  wire logic [3:0]            fast_shutdown_enable_i,
  input  wire logic                  fast_shutdown_input_i,
  input  wire logic                  priority_code_valid_i,
  input  wire logic [2:0]            priority_code_i,
  input  wire logic [11:0]           channel_priority_level_i,
  input  wire logic                  mem_enable_set_i,
  input  wire logic [7:0]            fw_revision_i,
  input  wire logic [7:0]            event_mask_i,
  output logic                       int_n_o,
  output logic                       supply_summary_flag_o,
  output logic [3:0]                 inrush_fault_o,
  output logic [3:0]                 cause_code_update_o,
  output logic [3:0]                 force_off_o,
  output logic [3:0]                 power_on_gated_o,
  output logic                       mem_enable_o,
  output logic                       safe_mode_o
);

  logic [3:0] class_cycle_flag;
  logic [3:0] detect_cycle_flag;
  logic [3:0] disconnect_flag;
  logic [3:0] overload_fault_flag;
  logic [3:0] current_limit_fault_flag;
  logic [3:0] start_fault_flag;
  logic [7:0] supply_reg;
  logic [3:0] supply_keep;  // bits 7:4, held across the reset pin
  logic [3:0] supply_live;  // bits 3:0, cleared by the reset pin
  logic       vpwr_lockout;
  logic [7:0] next_rd_data;
  logic [3:0] next_start;
  logic [3:0] fast_hit;

  // true when a read strobe carries the given clear-on-read code
  function automatic logic cr_hit(input logic rd, input logic [7:0] cmd,
                                  input logic [7:0] code);
    cr_hit = rd && (cmd == code);
  endfunction : cr_hit

  wire clr_detcls = cr_hit(rd_i, cmd_i, pfe_pkg::CMD_DETCLS_CR);
  wire clr_fault  = cr_hit(rd_i, cmd_i, pfe_pkg::CMD_FAULT_CR);
  wire clr_stlim  = cr_hit(rd_i, cmd_i, pfe_pkg::CMD_STLIM_CR);
  wire clr_supply = cr_hit(rd_i, cmd_i, pfe_pkg::CMD_SUPPLY_CR);

  // class and detect event sources; the set term is or-ed after the clears
  wire [3:0] class_set  = class_change_select_i ? chan_ev_i.class_changed
                                                : chan_ev_i.class_done;
  wire [3:0] detect_set = detect_change_select_i ? chan_ev_i.detect_changed
                                                 : chan_ev_i.detect_done;
  // supply droop alone keeps discovery flags; only falling through lockout wipes them
  wire       detcls_wipe = supply_i.vpwr_below_uvlo;

  // auto mode masks discovery errors so no start fault is raised from them
  always_comb begin
    next_start = chan_ev_i.start_timeout |
                 (chan_ev_i.start_discovery_err & ~chan_ev_i.auto_mode);
  end

  // per-channel fast shutdown compare, one slice per channel
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_fast
      assign fast_hit[g] = multibit_priority_select_i
        ? (priority_code_valid_i &&
           priority_code_i >= channel_priority_level_i[g*3 +: 3])
        : (fast_shutdown_enable_i[g] && fast_shutdown_input_i);
    end
  endgenerate

  // detection event register: clear first, then set wins
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      class_cycle_flag  <= pfe_pkg::NIBBLE_ZERO;
      detect_cycle_flag <= pfe_pkg::NIBBLE_ZERO;
    end else begin
      class_cycle_flag  <= ((clr_detcls || detcls_wipe) ? pfe_pkg::NIBBLE_ZERO
                            : class_cycle_flag & ~chan_ev_i.channel_off)
                           | class_set;
      detect_cycle_flag <= ((clr_detcls || detcls_wipe) ? pfe_pkg::NIBBLE_ZERO
                            : detect_cycle_flag & ~chan_ev_i.channel_off)
                           | detect_set;
    end
  end

  // fault register; counters live elsewhere, clearing here never touches them
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      disconnect_flag     <= pfe_pkg::NIBBLE_ZERO;
      overload_fault_flag <= pfe_pkg::NIBBLE_ZERO;
    end else begin
      disconnect_flag     <= (clr_fault ? pfe_pkg::NIBBLE_ZERO
                              : disconnect_flag & ~chan_ev_i.channel_off)
                             | chan_ev_i.disconnect;
      overload_fault_flag <= (clr_fault ? pfe_pkg::NIBBLE_ZERO
                              : overload_fault_flag & ~chan_ev_i.channel_off)
                             | chan_ev_i.overload;
    end
  end

  // start and current-limit register
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      current_limit_fault_flag <= pfe_pkg::NIBBLE_ZERO;
      start_fault_flag         <= pfe_pkg::NIBBLE_ZERO;
    end else begin
      current_limit_fault_flag <= (clr_stlim ? pfe_pkg::NIBBLE_ZERO
                                   : current_limit_fault_flag & ~chan_ev_i.channel_off)
                                  | chan_ev_i.current_limit;
      start_fault_flag         <= (clr_stlim ? pfe_pkg::NIBBLE_ZERO
                                   : start_fault_flag & ~chan_ev_i.channel_off)
                                  | next_start;
    end
  end

  // supply register lower nibble: reset pin clears fast-shutdown and memory flags
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      supply_live <= pfe_pkg::NIBBLE_ZERO;
    end else begin
      supply_live[pfe_pkg::SUP_FASTSD] <= (supply_live[pfe_pkg::SUP_FASTSD] & ~clr_supply)
                                          | (|fast_hit);
      supply_live[pfe_pkg::SUP_MEMFLT] <= (supply_live[pfe_pkg::SUP_MEMFLT] & ~clr_supply)
                                          | supply_i.mem_error;
      supply_live[3:2] <= 2'h0;
    end
  end

  // preserved flags are not on the pin reset at all, only on power-on
  // kept in a separate variable so each flop has exactly one process
  always_ff @(posedge sys_clk_i or posedge por_i) begin
    if (por_i) begin
      supply_keep <= pfe_pkg::SUP_POR_VALUE[7:4];
    end else begin
      supply_keep[pfe_pkg::SUP_THERMAL-4]  <= (supply_keep[pfe_pkg::SUP_THERMAL-4] & ~clr_supply)
                                              | supply_i.thermal;
      supply_keep[pfe_pkg::SUP_VDD_UV-4]   <= (supply_keep[pfe_pkg::SUP_VDD_UV-4] & ~clr_supply)
                                              | supply_i.vdd_uv | supply_i.vpwr_uv;
      supply_keep[pfe_pkg::SUP_VDD_WARN-4] <= (supply_keep[pfe_pkg::SUP_VDD_WARN-4] & ~clr_supply)
                                              | supply_i.vdd_warn;
      supply_keep[pfe_pkg::SUP_VPWR_UV-4]  <= (supply_keep[pfe_pkg::SUP_VPWR_UV-4] & ~clr_supply)
                                              | supply_i.vpwr_uv;
    end
  end

  // whole register view for the read mux and the summary
  assign supply_reg = {supply_keep, supply_live};

  // power-on gate latches with the undervoltage flag, lifted only above 30 V
  always_ff @(posedge sys_clk_i or posedge por_i) begin
    if (por_i) begin
      vpwr_lockout <= 1'b1;
    end else if (supply_i.vpwr_uv) begin
      vpwr_lockout <= 1'b1;
    end else if (supply_i.vpwr_above_30v) begin
      vpwr_lockout <= 1'b0;
    end
  end

  // safe mode and memory enable; only power-on or a host re-enable leaves it
  always_ff @(posedge sys_clk_i or posedge por_i) begin
    if (por_i) begin
      safe_mode_o  <= 1'b0;
      mem_enable_o <= 1'b0;
    end else if (supply_i.mem_error) begin
      safe_mode_o  <= 1'b1;
      mem_enable_o <= 1'b0;
    end else if (mem_enable_set_i) begin
      safe_mode_o  <= 1'b0;
      mem_enable_o <= 1'b1;
    end
  end

  // read mux; both codes of a pair return the same data
  always_comb begin
    case (cmd_i)
      pfe_pkg::CMD_DETCLS_RO,
      pfe_pkg::CMD_DETCLS_CR: next_rd_data = {class_cycle_flag, detect_cycle_flag};
      pfe_pkg::CMD_FAULT_RO,
      pfe_pkg::CMD_FAULT_CR:  next_rd_data = {disconnect_flag, overload_fault_flag};
      pfe_pkg::CMD_STLIM_RO,
      pfe_pkg::CMD_STLIM_CR:  next_rd_data = {current_limit_fault_flag,
                                              start_fault_flag};
      pfe_pkg::CMD_SUPPLY_RO,
      pfe_pkg::CMD_SUPPLY_CR: next_rd_data = supply_reg & pfe_pkg::SUP_LIVE_MASK;
      pfe_pkg::CMD_FWREV:     next_rd_data = safe_mode_o ? pfe_pkg::FWREV_SAFE
                                                         : fw_revision_i;
      default:                next_rd_data = pfe_pkg::UNMAPPED_DATA;
    endcase
  end

  // data captured on the read strobe, held until the next read
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_data_o <= pfe_pkg::UNMAPPED_DATA;
    end else if (rd_i) begin
      rd_data_o <= next_rd_data;
    end
  end

  // summary and channel side outputs
  assign supply_summary_flag_o = supply_reg[pfe_pkg::SUP_THERMAL] |
                                 supply_reg[pfe_pkg::SUP_VDD_UV] |
                                 supply_reg[pfe_pkg::SUP_VDD_WARN] |
                                 supply_reg[pfe_pkg::SUP_VPWR_UV] |
                                 supply_reg[pfe_pkg::SUP_MEMFLT];
  assign inrush_fault_o      = start_fault_flag & power_enable_change_flag_i;
  assign cause_code_update_o = next_start & ~power_enable_change_flag_i;
  // thermal trip holds only while hot, so the flag itself never blocks restart
  assign force_off_o = {4{supply_i.thermal}} |
                       ({4{safe_mode_o}} & ~channel_powered_i);
  assign power_on_gated_o = channel_power_on_command_i & {4{~vpwr_lockout}};

  // interrupt line: masked or of the event groups, falls away on clear-read
  wire [7:0] int_src = {supply_summary_flag_o, |start_fault_flag,
                        |{overload_fault_flag, current_limit_fault_flag},
                        |class_cycle_flag, |detect_cycle_flag, |disconnect_flag,
                        2'h0};
  assign int_n_o = ~|(int_src & event_mask_i);

  a_fault_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (clr_fault && !(|chan_ev_i.disconnect) && !(|chan_ev_i.overload))
      |=> (disconnect_flag == 4'h0 && overload_fault_flag == 4'h0))
    else $error("fault register not cleared by clear read");
  a_stlim_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (clr_stlim && !(|chan_ev_i.current_limit) && !(|next_start))
      |=> (current_limit_fault_flag == 4'h0 && start_fault_flag == 4'h0))
    else $error("start/limit register not cleared");
  a_set_wins: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (clr_fault && chan_ev_i.overload[0]) |=> overload_fault_flag[0])
    else $error("event lost to clear");
  a_ro_keeps: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (rd_i && cmd_i == pfe_pkg::CMD_FAULT_RO && !chan_ev_i.channel_off[1])
      |=> disconnect_flag[1] >= $past(disconnect_flag[1]))
    else $error("plain read altered fault bits");
  a_off_clears: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (chan_ev_i.channel_off[0] && !chan_ev_i.disconnect[0]) |=> !disconnect_flag[0])
    else $error("channel off did not clear");
  a_class_sel: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!class_change_select_i && chan_ev_i.class_done[0]) |=> class_cycle_flag[0])
    else $error("class cycle not flagged");
  a_detect_sel: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (detect_change_select_i && chan_ev_i.detect_changed[3]) |=> detect_cycle_flag[3])
    else $error("detect change not flagged");
  a_safe_rev: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (supply_i.mem_error ##1 (rd_i && cmd_i == pfe_pkg::CMD_FWREV && !mem_enable_set_i))
      |=> rd_data_o == pfe_pkg::FWREV_SAFE)
    else $error("revision not ffh in safe mode");
  a_auto_start: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (chan_ev_i.auto_mode[0] && !chan_ev_i.start_timeout[0]) |-> !next_start[0])
    else $error("start fault raised in auto mode");

  // multi-step behaviours are built from these named steps
  sequence s_fault_cr;
    rd_i && cmd_i == pfe_pkg::CMD_FAULT_CR;
  endsequence : s_fault_cr

  sequence s_stlim_cr;
    rd_i && cmd_i == pfe_pkg::CMD_STLIM_CR;
  endsequence : s_stlim_cr

  sequence s_mem_fault;
    supply_i.mem_error;
  endsequence : s_mem_fault

  // a clear read returns the value from before the clear
  a_fault_data: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_fault_cr |=> rd_data_o == $past({disconnect_flag, overload_fault_flag}))
    else $error("fault clear read returned wrong data");
  a_stlim_data: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_stlim_cr |=> rd_data_o == $past({current_limit_fault_flag, start_fault_flag}))
    else $error("start/limit clear read returned wrong data");

  // with no supply condition standing, a clear read empties the register
  a_supply_clear: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (clr_supply && supply_i == '0 && !(|fast_hit)) |=> supply_reg == 8'h00)
    else $error("supply register not cleared");

  // disconnect alone unmasked: clearing it must release the line
  a_int_release: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (event_mask_i == 8'h04 && clr_fault && !(|chan_ev_i.disconnect)) |=> int_n_o)
    else $error("interrupt not released by clear read");

  // individual event flags land one cycle after their pulse
  a_disc_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    chan_ev_i.disconnect[2] |=> disconnect_flag[2])
    else $error("disconnect not flagged");
  a_limit_set: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    chan_ev_i.current_limit[3] |=> current_limit_fault_flag[3])
    else $error("current limit not flagged");

  // a hot die forces every channel off and latches the flag
  a_thermal_off: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    supply_i.thermal |-> (force_off_o == 4'hf) ##1 supply_reg[pfe_pkg::SUP_THERMAL])
    else $error("thermal shutdown not applied");

  // no power-on command passes while the supply lockout stands
  a_uv_gate: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    vpwr_lockout |-> power_on_gated_o == 4'h0)
    else $error("power-on command passed in lockout");

  // falling through lockout wipes discovery flags unless a new event lands
  a_uv_wipe: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (supply_i.vpwr_below_uvlo && !(|detect_set) && !(|class_set))
      |=> (detect_cycle_flag == 4'h0 && class_cycle_flag == 4'h0))
    else $error("discovery flags kept below lockout");

  // single-bit shutdown on an enabled channel raises the group flag
  a_fast_single: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    (!multibit_priority_select_i && fast_shutdown_enable_i[1] && fast_shutdown_input_i)
      |=> supply_reg[pfe_pkg::SUP_FASTSD])
    else $error("fast shutdown not flagged");

  // memory fault: safe mode entered, memory disabled, flag set
  a_safe_enter: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    s_mem_fault |=> (safe_mode_o && !mem_enable_o && supply_reg[pfe_pkg::SUP_MEMFLT]))
    else $error("memory fault did not enter safe mode");
endmodule : pfe_flags

`default_nettype wire

// [bench/pfe_host_model.sv]
/*
  Host side model for the flag bank: issues command-code reads.
  Assumes reads are called at a falling clock edge and that the bank
  answers with registered data held until the next read.
*/
`timescale 1ns/1ns
`default_nettype none
module pfe_host_model (
  input  wire logic       sys_clk_i,
  input  wire logic       safe_mode_i,
  output logic            rd_o,
  output logic [7:0]      cmd_o,
  input  wire logic [7:0] rd_data_i
);
  initial begin
    rd_o  = 1'b0;
    cmd_o = 8'h00;
  end

  // one read: strobe for one cycle, data taken a full cycle later
  task automatic read(input logic [7:0] code, input logic frc, output logic [7:0] data);
    if (safe_mode_i && !frc) begin
      data = 8'hxx;
      return;
    end
    rd_o  = 1'b1;
    cmd_o = code;
    @(negedge sys_clk_i);
    rd_o  = 1'b0;
    cmd_o = ~code; // idle code lines never repeat the last command
    @(negedge sys_clk_i);
    data = rd_data_i;
  endtask : read
endmodule : pfe_host_model
`default_nettype wire

// [bench/test_pfe_flags.sv]
/*
  Self-checking bench for the flag bank: pulses events, reads by code.
  Assumes the host model and the bank share one 50 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
module test_pfe_flags;
  logic                  sys_clk_i = 1'b0;
  logic                  rst_i     = 1'b1;
  logic                  por_i     = 1'b1;
  logic                  rd;
  logic [7:0]            cmd;
  logic [7:0]            rd_data;
  pfe_pkg::pfe_chan_ev_t ev        = '0;
  pfe_pkg::pfe_supply_t  sup       = '0;
  logic                  ccs       = 1'b0;
  logic                  dcs       = 1'b0;
  logic [3:0]            power_enable_change_flag       = 4'h0;
  logic [3:0]            pwr_cmd   = 4'h0;
  logic [3:0]            powered   = 4'h0;
  logic                  channel_priority_level       = 1'b0;
  logic [3:0]            fse       = 4'h0;
  logic                  fsi       = 1'b0;
  logic                  pcv       = 1'b0;
  logic [2:0]            pcode     = 3'h0;
  logic [11:0]           plevel    = 12'h000;
  logic                  mes       = 1'b0;
  logic [7:0]            fwrev     = 8'h3c;
  logic [7:0]            emask     = 8'h00;
  logic                  int_n, summ, mem_en, safe;
  logic [3:0]            inrush, cause, foff, gated;
  int                    bad_count   = 0;
  int                    checks_done = 0;

  always #10 sys_clk_i = ~sys_clk_i;

  pfe_flags u_pfe_flags (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .por_i(por_i), .rd_i(rd), .cmd_i(cmd),
    .rd_data_o(rd_data), .chan_ev_i(ev), .supply_i(sup),
    .class_change_select_i(ccs), .detect_change_select_i(dcs),
    .power_enable_change_flag_i(power_enable_change_flag), .channel_power_on_command_i(pwr_cmd),
    .channel_powered_i(powered), .multibit_priority_select_i(channel_priority_level),
    .fast_shutdown_enable_i(fse), .fast_shutdown_input_i(fsi),
    .priority_code_valid_i(pcv), .priority_code_i(pcode),
    .channel_priority_level_i(plevel), .mem_enable_set_i(mes),
    .fw_revision_i(fwrev), .event_mask_i(emask), .int_n_o(int_n),
    .supply_summary_flag_o(summ), .inrush_fault_o(inrush),
    .cause_code_update_o(cause), .force_off_o(foff), .power_on_gated_o(gated),
    .mem_enable_o(mem_en), .safe_mode_o(safe)
  );

  pfe_host_model u_pfe_host_model (
    .sys_clk_i(sys_clk_i), .safe_mode_i(safe), .rd_o(rd), .cmd_o(cmd),
    .rd_data_i(rd_data)
  );

  task automatic conclude;
    if (bad_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  // read through the host model and compare
  task automatic rd_chk(input logic [7:0] code, input logic [7:0] exp, input logic frc = 1'b0);
    logic [7:0] got;
    u_pfe_host_model.read(code, frc, got);
    chk(got, exp);
  endtask : rd_chk

  // one cycle of event pulses, then all pulses drop
  task automatic step;
    @(negedge sys_clk_i);
    ev  = '0;
    sup = '0;
    fsi = 1'b0;
    pcv = 1'b0;
    mes = 1'b0;
  endtask : step

  // watchdog: the sequence needs under a hundred cycles
  initial begin
    repeat (3000) @(posedge sys_clk_i);
    bad_count++;
    conclude();
  end

  initial begin
    repeat (5) @(negedge sys_clk_i);
    rst_i = 1'b0;
    por_i = 1'b0;
    chk({7'h00, summ}, 8'h01);
    rd_chk(pfe_pkg::CMD_SUPPLY_RO, 8'h70);
    rd_chk(pfe_pkg::CMD_SUPPLY_CR, 8'h70);
    rd_chk(pfe_pkg::CMD_SUPPLY_RO, 8'h00);
    chk({7'h00, summ}, 8'h00);
    rd_chk(pfe_pkg::CMD_FAULT_RO, 8'h00);
    rd_chk(8'h3c, 8'h00);
    // supply lockout gates power-on commands
    pwr_cmd = 4'h5;
    #1 chk({4'h0, gated}, 8'h00);
    sup.vpwr_above_30v = 1'b1;
    step();
    chk({4'h0, gated}, 8'h05);
    // disconnect and overload, interrupt release
    emask = 8'h04;
    ev.disconnect = 4'h4;
    ev.overload = 4'h1;
    step();
    chk({7'h00, int_n}, 8'h00);
    rd_chk(pfe_pkg::CMD_FAULT_RO, 8'h41);
    rd_chk(pfe_pkg::CMD_FAULT_RO, 8'h41);
    rd_chk(pfe_pkg::CMD_FAULT_CR, 8'h41);
    chk({7'h00, int_n}, 8'h01);
    rd_chk(pfe_pkg::CMD_FAULT_RO, 8'h00);
    // limit and start faults, inrush decode
    ev.current_limit = 4'h8;
    ev.start_timeout = 4'h2;
    power_enable_change_flag = 4'h2;
    step();
    chk({4'h0, inrush}, 8'h02);
    rd_chk(pfe_pkg::CMD_STLIM_RO, 8'h82);
    rd_chk(pfe_pkg::CMD_STLIM_CR, 8'h82);
    rd_chk(pfe_pkg::CMD_STLIM_RO, 8'h00);
    power_enable_change_flag = 4'h0;
    ev.auto_mode = 4'h1;
    ev.start_discovery_err = 4'h1;
    step();
    rd_chk(pfe_pkg::CMD_STLIM_RO, 8'h00);
    ev.start_discovery_err = 4'h1;
    step();
    rd_chk(pfe_pkg::CMD_STLIM_CR, 8'h01);
    // cycle flags versus change flags
    ev.class_done = 4'h1;
    ev.detect_done = 4'h2;
    step();
    rd_chk(pfe_pkg::CMD_DETCLS_CR, 8'h12);
    ccs = 1'b1;
    dcs = 1'b1;
    ev.class_done = 4'hf;
    ev.detect_done = 4'hf;
    step();
    rd_chk(pfe_pkg::CMD_DETCLS_RO, 8'h00);
    ev.class_done = 4'hf;
    ev.detect_done = 4'hf;
    ev.class_changed = 4'h4;
    ev.detect_changed = 4'h8;
    step();
    rd_chk(pfe_pkg::CMD_DETCLS_CR, 8'h48);
    ccs = 1'b0;
    dcs = 1'b0;
    // turning channel 0 off clears only its bits
    ev.disconnect = 4'h3;
    ev.current_limit = 4'h3;
    ev.detect_done = 4'h3;
    step();
    ev.channel_off = 4'h1;
    step();
    rd_chk(pfe_pkg::CMD_FAULT_CR, 8'h20);
    rd_chk(pfe_pkg::CMD_STLIM_CR, 8'h20);
    rd_chk(pfe_pkg::CMD_DETCLS_CR, 8'h02);
    // event lands on the clearing edge
    ev.overload = 4'h1;
    fork
      rd_chk(pfe_pkg::CMD_FAULT_CR, 8'h00);
      step();
    join
    rd_chk(pfe_pkg::CMD_FAULT_RO, 8'h01);
    // thermal flag survives the reset pin, channel flags do not
    sup.thermal = 1'b1;
    #1 chk({4'h0, foff}, 8'h0f);
    step();
    rst_i = 1'b1;
    @(negedge sys_clk_i);
    rst_i = 1'b0;
    rd_chk(pfe_pkg::CMD_SUPPLY_RO, 8'h80);
    rd_chk(pfe_pkg::CMD_FAULT_RO, 8'h00);
    rd_chk(pfe_pkg::CMD_SUPPLY_CR, 8'h80);
    // fast shutdown, single-bit then priority code
    fsi = 1'b1;
    step();
    rd_chk(pfe_pkg::CMD_SUPPLY_RO, 8'h00);
    fse = 4'h2;
    fsi = 1'b1;
    step();
    rd_chk(pfe_pkg::CMD_SUPPLY_CR, 8'h02);
    channel_priority_level = 1'b1;
    plevel = 12'hffd;
    pcode = 3'h4;
    pcv = 1'b1;
    step();
    rd_chk(pfe_pkg::CMD_SUPPLY_RO, 8'h00);
    pcode = 3'h5;
    pcv = 1'b1;
    step();
    rd_chk(pfe_pkg::CMD_SUPPLY_CR, 8'h02);
    channel_priority_level = 1'b0;
    // memory fault, safe mode and recovery
    powered = 4'h3;
    rd_chk(pfe_pkg::CMD_FWREV, 8'h3c);
    sup.mem_error = 1'b1;
    step();
    chk({6'h00, safe, mem_en}, 8'h02);
    chk({4'h0, foff}, 8'h0c);
    chk({7'h00, summ}, 8'h01);
    rd_chk(pfe_pkg::CMD_FWREV, 8'hff, 1'b1);
    rd_chk(pfe_pkg::CMD_SUPPLY_CR, 8'h01, 1'b1);
    mes = 1'b1;
    step();
    chk({6'h00, safe, mem_en}, 8'h01);
    rd_chk(pfe_pkg::CMD_FWREV, 8'h3c);
    // detect flags kept in undervoltage, lost below lockout
    ev.detect_done = 4'h1;
    sup.vpwr_uv = 1'b1;
    step();
    rd_chk(pfe_pkg::CMD_DETCLS_RO, 8'h01);
    sup.vpwr_uv = 1'b1;
    sup.vpwr_below_uvlo = 1'b1;
    step();
    rd_chk(pfe_pkg::CMD_DETCLS_RO, 8'h00);
    conclude();
  end
endmodule : test_pfe_flags
`default_nettype wire
